/* File: tpc_pkg.sv */
/*
 package for the T1 performance counter and interrupt word block:
 register offsets, bit positions, reset values, thresholds, timing.
 assumes one 200 MHz clock shared by the block and its event sources.
*/
// Function
// - four-bit frame loss count in upper nibble, +1 per sync loss
// - four-bit realign count in lower nibble, +1 when resync moves alignment
// - eight-bit count, +1 per multiframe with frame sync lost
// - sixteen-bit line violation count shown as high and low bytes
// - sixteen-bit checksum error count shown as high and low bytes
// - interrupt bits set only when unmasked, cleared by reading word
// - word zero bit 7 set on any terminal sync change
// - word zero bit 6 set on multiframe sync change; bit 5 unused
// - word zero bit 4 set when all-ones condition starts or stops
// - word zero bit 3 set when loss of signal begins or ends
// - word zero bit 2 set on two framing errors within six
// - word zero bit 1 set on transmit controlled slip
// - word zero bit 0 set on receive controlled slip
// - word one bit 7 set on framing bit error while in sync
// - word one bit 6 set on local checksum mismatch
// - word one bit 5 set on remote yellow alarm
// - word one bit 4 set when reframe changes alignment
// - word one bit 3 set per violation, except coding substitutions
// - word one bit 2 set on test pattern error
// - no substitution coding: bit 1 on 16 zeros or low density
// - substitution coding: bit 1 on 8 zeros; word one bit 0 unused
// - counters wrap from all ones to zero, reported as overflow
package tpc_pkg;
    localparam int unsigned ADDR_W = 5;
    localparam logic [4:0] OFS_FRM  = 5'h14;
    localparam logic [4:0] OFS_MFL  = 5'h15;
    localparam logic [4:0] OFS_BPVH = 5'h16;
    localparam logic [4:0] OFS_BPVL = 5'h17;
    localparam logic [4:0] OFS_CRCH = 5'h18;
    localparam logic [4:0] OFS_CRCL = 5'h19;
    localparam logic [4:0] OFS_IRQ0 = 5'h1B;
    localparam logic [4:0] OFS_IRQ1 = 5'h1C;
    // word zero bit positions
    localparam int unsigned B0_TFSYN = 7;
    localparam int unsigned B0_MFSYN = 6;
    localparam int unsigned B0_AIS   = 4;
    localparam int unsigned B0_LOS   = 3;
    localparam int unsigned B0_SEV   = 2;
    localparam int unsigned B0_TXS   = 1;
    localparam int unsigned B0_RXS   = 0;
    // word one bit positions
    localparam int unsigned B1_FBE  = 7;
    localparam int unsigned B1_CRC  = 6;
    localparam int unsigned B1_YEL  = 5;
    localparam int unsigned B1_COFA = 4;
    localparam int unsigned B1_BPV  = 3;
    localparam int unsigned B1_PRBS = 2;
    localparam int unsigned B1_PDV  = 1;
    localparam logic [7:0]  RST8   = 8'h00;
    localparam logic [15:0] RST16  = 16'h0000;
    localparam logic [4:0]  PDV_ZAMI  = 5'h10;
    localparam logic [4:0]  PDV_ZB8ZS = 5'h08;
    localparam int unsigned SEV_HIST = 5;
    localparam int unsigned TMR_W    = 20;
    localparam int unsigned CLK_MHZ   = 200;
    localparam int unsigned MF_D4_US  = 1500;
    localparam int unsigned MF_ESF_US = 3000;
    localparam int unsigned MF_D4_CYC  = MF_D4_US * CLK_MHZ;
    localparam int unsigned MF_ESF_CYC = MF_ESF_US * CLK_MHZ;

    typedef struct packed {
        logic tfsync;
        logic mfsync;
        logic ais;
        logic los;
        logic resync_done;
        logic align_moved;
        logic mf_start;
        logic esf;
        logic bpv;
        logic bpv_subst;
        logic crc_err;
        logic tx_slip;
        logic rx_slip;
        logic fbit_valid;
        logic fbit_bad;
        logic yellow;
        logic prbs_err;
        logic bit_valid;
        logic bit_one;
        logic b8zs;
        logic density_low;
    } tpc_ev_s;

    typedef struct packed {
        logic frame_loss;
        logic realign;
        logic mf_loss;
        logic bpv;
        logic crc;
    } tpc_ovf_s;
endpackage

/* File: tpc_perf_irq.sv */
/*
 performance counters and interrupt words zero and one, read through
 the page register port. assumes all event inputs come from logic on
 sys_clk_in, pulses last one cycle, and rd_stb_in is one cycle per read.
*/
`timescale 1ns/100ps
module tpc_perf_irq #(
    parameter int unsigned MF_D4_CYCLES  = tpc_pkg::MF_D4_CYC,
    parameter int unsigned MF_ESF_CYCLES = tpc_pkg::MF_ESF_CYC
) (
    input  wire logic                       sys_clk_in,
    input  wire logic                       rstn_in,
    input  wire logic                       rd_stb_in,
    input  wire logic [tpc_pkg::ADDR_W-1:0] rd_addr_in,
    output logic      [7:0]                 rd_data_out,
    input  wire tpc_pkg::tpc_ev_s           ev_in,
    input  wire logic [7:0]                 unmask0_in,
    input  wire logic [7:0]                 unmask1_in,
    output logic      [7:0]                 irq0_out,
    output logic      [7:0]                 irq1_out,
    output tpc_pkg::tpc_ovf_s               ovf_out
);
    import tpc_pkg::*;

    typedef logic [TMR_W-1:0] tpc_tmr_t;
    localparam tpc_tmr_t D4_LAST  = tpc_tmr_t'(MF_D4_CYCLES - 1);
    localparam tpc_tmr_t ESF_LAST = tpc_tmr_t'(MF_ESF_CYCLES - 1);

    logic [3:0]          frame_loss_count_q;
    logic [3:0]          realign_count_q;
    logic [7:0]          mfl_q;
    logic [15:0]         bpv_q;
    logic [15:0]         crc_q;
    logic [7:0]          bpv_snap_q;
    logic [7:0]          crc_snap_q;
    logic                bpv_hold_q;
    logic                crc_hold_q;
    logic [7:0]          irq0_q;
    logic [7:0]          irq1_q;
    logic [7:0]          rdata_q;
    tpc_ovf_s            ovf_q;
    logic [3:0]          prev_q;
    tpc_tmr_t            tmr_q;
    logic                lost_seen_q;
    logic [4:0]          zrun_q;
    logic [SEV_HIST-1:0] fb_hist_q;
    logic [7:0]          set0;
    logic [7:0]          set1;
    logic [7:0]          set0_m;
    logic [7:0]          set1_m;
    logic                fl_inc;
    logic                ra_inc;
    logic                mf_edge;
    logic                mf_inc;
    logic                zero_hit;
    logic                sev_set;
    logic                rd0;
    logic                rd1;
    logic [4:0]          zthr;

    // returns the frozen low byte after a high byte read until the low byte is read
    function automatic logic [7:0] low_byte(input logic hold,
                                            input logic [7:0] snap,
                                            input logic [7:0] live);
        return hold ? snap : live;
    endfunction

    assign fl_inc = prev_q[3] & ~ev_in.tfsync;
    assign ra_inc = ev_in.resync_done & ev_in.align_moved;
    assign rd0    = rd_stb_in & (rd_addr_in == OFS_IRQ0);
    assign rd1    = rd_stb_in & (rd_addr_in == OFS_IRQ1);
    assign zthr   = ev_in.b8zs ? PDV_ZB8ZS : PDV_ZAMI;

    // multiframe period follows the framing format
    assign mf_edge = ev_in.mf_start
                   | (tmr_q == (ev_in.esf ? ESF_LAST : D4_LAST));
    assign mf_inc  = mf_edge & (lost_seen_q | ~ev_in.tfsync);

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tmr_q       <= '0;
            lost_seen_q <= 1'b0;
        end else if (mf_edge) begin
            tmr_q       <= '0;
            lost_seen_q <= 1'b0;
        end else begin
            tmr_q       <= tpc_tmr_t'(tmr_q + 1'b1);
            lost_seen_q <= lost_seen_q | ~ev_in.tfsync;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            frame_loss_count_q <= RST8[3:0];
            realign_count_q    <= RST8[3:0];
            mfl_q              <= RST8;
        end else begin
            if (fl_inc) begin
                frame_loss_count_q <= 4'(frame_loss_count_q + 4'h1);
            end
            if (ra_inc) begin
                realign_count_q <= 4'(realign_count_q + 4'h1);
            end
            if (mf_inc) begin
                mfl_q <= 8'(mfl_q + 8'h01);
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bpv_q <= RST16;
            crc_q <= RST16;
        end else begin
            if (ev_in.bpv) begin
                bpv_q <= 16'(bpv_q + 16'h0001);
            end
            if (ev_in.crc_err) begin
                crc_q <= 16'(crc_q + 16'h0001);
            end
        end
    end

    // overflow pulses on the all-ones to zero step
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ovf_q <= '0;
        end else begin
            ovf_q.frame_loss <= fl_inc & (&frame_loss_count_q);
            ovf_q.realign    <= ra_inc & (&realign_count_q);
            ovf_q.mf_loss    <= mf_inc & (&mfl_q);
            ovf_q.bpv        <= ev_in.bpv & (&bpv_q);
            ovf_q.crc        <= ev_in.crc_err & (&crc_q);
        end
    end

    // pulse density: zero run saturates so each run fires once
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            zrun_q <= '0;
        end else if (ev_in.bit_valid) begin
            if (ev_in.bit_one) begin
                zrun_q <= '0;
            end else if (zrun_q < zthr) begin
                zrun_q <= 5'(zrun_q + 5'h01);
            end
        end
    end
    assign zero_hit = ev_in.bit_valid & ~ev_in.bit_one
                    & (zrun_q == 5'(zthr - 5'h01));

    // framing bit error history over the last five framing bits
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fb_hist_q <= '0;
        end else if (ev_in.fbit_valid) begin
            fb_hist_q <= {fb_hist_q[SEV_HIST-2:0], ev_in.fbit_bad};
        end
    end
    assign sev_set = ev_in.fbit_valid & ev_in.fbit_bad & (|fb_hist_q);

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prev_q <= '0;
        end else begin
            prev_q <= {ev_in.tfsync, ev_in.mfsync, ev_in.ais, ev_in.los};
        end
    end

    always_comb begin
        set0           = '0;
        set0[B0_TFSYN] = prev_q[3] ^ ev_in.tfsync;
        set0[B0_MFSYN] = prev_q[2] ^ ev_in.mfsync;
        set0[B0_AIS]   = prev_q[1] ^ ev_in.ais;
        set0[B0_LOS]   = prev_q[0] ^ ev_in.los;
        set0[B0_SEV]   = sev_set;
        set0[B0_TXS]   = ev_in.tx_slip;
        set0[B0_RXS]   = ev_in.rx_slip;
        set1           = '0;
        set1[B1_FBE]   = ev_in.fbit_valid & ev_in.fbit_bad
                       & ev_in.tfsync;
        set1[B1_CRC]   = ev_in.crc_err;
        set1[B1_YEL]   = ev_in.yellow;
        set1[B1_COFA]  = ra_inc;
        set1[B1_BPV]   = ev_in.bpv & ~ev_in.bpv_subst;
        set1[B1_PRBS]  = ev_in.prbs_err;
        set1[B1_PDV]   = zero_hit
                       | (ev_in.density_low & ~ev_in.b8zs);
    end
    assign set0_m = set0 & unmask0_in;
    assign set1_m = set1 & unmask1_in;

    // a set in the clearing cycle wins over the clear
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq0_q <= RST8;
            irq1_q <= RST8;
        end else begin
            irq0_q <= (rd0 ? RST8 : irq0_q) | set0_m;
            irq1_q <= (rd1 ? RST8 : irq1_q) | set1_m;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bpv_snap_q <= RST8;
            crc_snap_q <= RST8;
            bpv_hold_q <= 1'b0;
            crc_hold_q <= 1'b0;
        end else if (rd_stb_in) begin
            if (rd_addr_in == OFS_BPVH) begin
                bpv_snap_q <= bpv_q[7:0];
                bpv_hold_q <= 1'b1;
            end else if (rd_addr_in == OFS_BPVL) begin
                bpv_hold_q <= 1'b0;
            end
            if (rd_addr_in == OFS_CRCH) begin
                crc_snap_q <= crc_q[7:0];
                crc_hold_q <= 1'b1;
            end else if (rd_addr_in == OFS_CRCL) begin
                crc_hold_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_q <= RST8;
        end else if (rd_stb_in) begin
            unique case (rd_addr_in)
                OFS_FRM:  rdata_q <= {frame_loss_count_q,
                                      realign_count_q};
                OFS_MFL:  rdata_q <= mfl_q;
                OFS_BPVH: rdata_q <= bpv_q[15:8];
                OFS_BPVL: rdata_q <= low_byte(bpv_hold_q, bpv_snap_q,
                                              bpv_q[7:0]);
                OFS_CRCH: rdata_q <= crc_q[15:8];
                OFS_CRCL: rdata_q <= low_byte(crc_hold_q, crc_snap_q,
                                              crc_q[7:0]);
                OFS_IRQ0: rdata_q <= irq0_q;
                OFS_IRQ1: rdata_q <= irq1_q;
                default:  rdata_q <= RST8;
            endcase
        end
    end

    assign rd_data_out = rdata_q;
    assign irq0_out    = irq0_q;
    assign irq1_out    = irq1_q;
    assign ovf_out     = ovf_q;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);

    sequence s_rd_irq0_quiet;
        rd0 && (set0_m == 8'h00);
    endsequence

    sequence s_high_then_low;
        rd_stb_in && (rd_addr_in == OFS_BPVH) && !ev_in.bpv
        ##1 !rd_stb_in
        ##1 rd_stb_in && (rd_addr_in == OFS_BPVL);
    endsequence

    property p_frame_loss;
        $fell(ev_in.tfsync) |=> frame_loss_count_q ==
            4'($past(frame_loss_count_q) + 4'h1);
    endproperty
    a_frame_loss: assert property (p_frame_loss)
        else $error("frame loss count did not step");

    property p_realign;
        ev_in.resync_done && !ev_in.align_moved |=>
            $stable(realign_count_q)
            && (!irq1_q[B1_COFA] || $past(irq1_q[B1_COFA]));
    endproperty
    a_realign: assert property (p_realign)
        else $error("realign count moved without alignment shift");

    property p_mf_count;
        mf_edge && !ev_in.tfsync |=> mfl_q == 8'($past(mfl_q) + 8'h01);
    endproperty
    a_mf_count: assert property (p_mf_count)
        else $error("multiframe loss count did not step");

    property p_bpv_wrap;
        ev_in.bpv && (bpv_q == 16'hFFFF) |=> (bpv_q == 16'h0000)
            && ovf_q.bpv;
    endproperty
    a_bpv_wrap: assert property (p_bpv_wrap)
        else $error("violation counter did not wrap with overflow");

    property p_masked;
        1'b1 |=> (irq1_q & ~$past(irq1_q) & ~$past(unmask1_in)) == 8'h00;
    endproperty
    a_masked: assert property (p_masked)
        else $error("masked interrupt bit was set");

    property p_read_clear;
        s_rd_irq0_quiet |=> (irq0_q == 8'h00)
            && (rd_data_out == $past(irq0_q));
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("word zero read did not return and clear");

    property p_set_wins;
        rd1 && (set1_m != 8'h00) |=> (irq1_q == $past(set1_m))
            ##1 ($past(rd1)
                 || ((irq1_q & $past(set1_m, 2)) == $past(set1_m, 2)));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost against clearing read");

    property p_unused;
        !irq0_q[5] && !irq1_q[0];
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused interrupt bit set");

    property p_fbe_sync;
        ev_in.fbit_valid && ev_in.fbit_bad && !ev_in.tfsync
            && !irq1_q[B1_FBE] && !rd1 |=> !irq1_q[B1_FBE];
    endproperty
    a_fbe_sync: assert property (p_fbe_sync)
        else $error("framing error flagged out of sync");

    property p_pair;
        s_high_then_low |=> rd_data_out == $past(bpv_q[7:0], 3);
    endproperty
    a_pair: assert property (p_pair)
        else $error("low byte not frozen after high byte read");

endmodule // tpc_perf_irq

/* File: tpc_host_model.sv */
/*
 host side of the page register port: issues one-cycle read strobes.
 assumes callers enter rd about 1 ns after a rising edge of sys_clk_in.
*/
`timescale 1ns/100ps
module tpc_host_model (
    input  wire logic                       sys_clk_in,
    output logic                            rd_stb_out,
    output logic      [tpc_pkg::ADDR_W-1:0] rd_addr_out,
    input  wire logic [7:0]                 rd_data_in
);
    initial begin
        rd_stb_out  = 1'b0;
        rd_addr_out = '0;
    end

    // an edge passes after release so the strobe is never re-raised at once
    task automatic rd(input logic [tpc_pkg::ADDR_W-1:0] a,
                      output logic [7:0] d);
        rd_stb_out  = 1'b1;
        rd_addr_out = a;
        @(posedge sys_clk_in);
        #1;
        rd_stb_out  = 1'b0;
        rd_addr_out = ~a;
        d           = rd_data_in;
        @(posedge sys_clk_in);
        #1;
    endtask
endmodule // tpc_host_model

/* File: tpc_perf_irq_tb_top.sv */
/*
 self-checking bench for the counter and interrupt word block.
 assumes the host model for reads and short multiframe parameters.
*/
`timescale 1ns/100ps
module tpc_perf_irq_tb_top;
    import tpc_pkg::*;
    localparam int TF = 20, MF = 19, AIS = 18, LOS = 17, RSD = 16;
    localparam int ALM = 15, MFS = 14, ESF = 13, BPV = 12, SUB = 11;
    localparam int CRC = 10, TXS = 9, RXS = 8, FBV = 7, FBB = 6;
    localparam int YEL = 5, PRB = 4, BV = 3, B1 = 2, B8 = 1, DL = 0;
    logic           sys_clk_in = 1'b0;
    logic           rstn_in    = 1'b0;
    logic           rd_stb;
    logic [4:0]     rd_addr;
    logic [7:0]     rd_data, irq0, irq1, d;
    logic [7:0]     um0        = 8'hFF;
    logic [7:0]     um1        = 8'hFF;
    tpc_ev_s        ev;
    tpc_ovf_s       ovf;
    int             fail_count = 0;
    int             num_checks = 0;
    int             cyc        = 0;
    int             ovf_n      = 0;
    int             lv[3]      = '{MF, AIS, LOS};
    int             bt[3]      = '{6, 4, 3};

    always #2.5 sys_clk_in = ~sys_clk_in;

    tpc_perf_irq #(.MF_D4_CYCLES(20), .MF_ESF_CYCLES(40)) tpc_perf_irq_inst (
        .sys_clk_in  (sys_clk_in),
        .rstn_in     (rstn_in),
        .rd_stb_in   (rd_stb),
        .rd_addr_in  (rd_addr),
        .rd_data_out (rd_data),
        .ev_in       (ev),
        .unmask0_in  (um0),
        .unmask1_in  (um1),
        .irq0_out    (irq0),
        .irq1_out    (irq1),
        .ovf_out     (ovf)
    );

    tpc_host_model tpc_host_model_inst (
        .sys_clk_in  (sys_clk_in),
        .rd_stb_out  (rd_stb),
        .rd_addr_out (rd_addr),
        .rd_data_in  (rd_data)
    );

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic tick(input int n = 1);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    task automatic pulse(input int i);
        ev[i] = 1'b1;
        tick();
        ev[i] = 1'b0;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        tpc_host_model_inst.rd(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask

    // framing bits: five good to flush history, one bad, n good, one bad
    task automatic sev(input int n);
        ev[FBV] = 1'b1;
        ev[FBB] = 1'b0;
        tick(5);
        ev[FBB] = 1'b1;
        tick();
        ev[FBB] = 1'b0;
        tick(n);
        ev[FBB] = 1'b1;
        tick();
        ev[FBV] = 1'b0;
        ev[FBB] = 1'b0;
    endtask

    // run of n received zeros, checked one short and then at length
    task automatic zrun(input int n);
        ev[BV] = 1'b1;
        ev[B1] = 1'b1;
        tick();
        ev[B1] = 1'b0;
        tick(n - 1);
        ev[BV] = 1'b0;
        rdc(5'h1C, 8'h00);
        ev[BV] = 1'b1;
        tick();
        ev[BV] = 1'b0;
        rdc(5'h1C, 8'h02);
    endtask

    always @(posedge sys_clk_in) begin
        if (ovf.realign === 1'b1) begin
            ovf_n++;
        end
    end

    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            results();
        end
    end

    initial begin
        ev     = '0;
        ev[TF] = 1'b1;
        tick(12);
        rstn_in = 1'b1;
        tick();
        rdc(5'h1B, 8'h80);
        rdc(5'h1B, 8'h00);
        for (int a = 'h14; a <= 'h1C; a++) begin
            rdc(a[4:0], 8'h00);
        end
        for (int k = 0; k < 3; k++) begin
            ev[lv[k]] = 1'b1;
            tick();
            rdc(5'h1B, 8'h01 << bt[k]);
            rdc(5'h1B, 8'h00);
            ev[lv[k]] = 1'b0;
            tick();
            rdc(5'h1B, 8'h01 << bt[k]);
        end
        pulse(TXS);
        chk("irq0_out", 8'h02, irq0);
        rdc(5'h1B, 8'h02);
        pulse(RXS);
        rdc(5'h1B, 8'h01);
        um0 = 8'hFD;
        pulse(TXS);
        um0 = 8'hFF;
        tick();
        rdc(5'h1B, 8'h00);
        fork
            tpc_host_model_inst.rd(5'h1B, d);
            pulse(RXS);
        join
        chk("word zero", 8'h00, d);
        rdc(5'h1B, 8'h01);
        fork
            tpc_host_model_inst.rd(5'h1C, d);
            pulse(YEL);
        join
        chk("word one", 8'h00, d);
        rdc(5'h1C, 8'h20);
        pulse(MFS);
        ev[TF] = 1'b0;
        ev[FBV] = 1'b1;
        ev[FBB] = 1'b1;
        tick();
        ev[TF] = 1'b1;
        ev[FBV] = 1'b0;
        ev[FBB] = 1'b0;
        tick(25);
        rdc(5'h15, 8'h01);
        rdc(5'h14, 8'h10);
        rdc(5'h1B, 8'h80);
        rdc(5'h1C, 8'h00);
        ev[ESF] = 1'b1;
        pulse(MFS);
        ev[TF] = 1'b0;
        tick();
        ev[TF] = 1'b1;
        tick(30);
        rdc(5'h15, 8'h01);
        tick(12);
        rdc(5'h15, 8'h02);
        rdc(5'h1B, 8'h80);
        sev(5);
        rdc(5'h1B, 8'h00);
        rdc(5'h1C, 8'h80);
        sev(4);
        rdc(5'h1B, 8'h04);
        rdc(5'h1C, 8'h80);
        pulse(RSD);
        rdc(5'h14, 8'h20);
        rdc(5'h1C, 8'h00);
        ev[ALM] = 1'b1;
        pulse(RSD);
        rdc(5'h14, 8'h21);
        rdc(5'h1C, 8'h10);
        ev[RSD] = 1'b1;
        tick(15);
        ev[RSD] = 1'b0;
        tick(3);
        rdc(5'h14, 8'h20);
        chk("realign overflow", 8'h01, ovf_n[7:0]);
        ev[SUB] = 1'b1;
        pulse(BPV);
        rdc(5'h1C, 8'h10);
        ev[SUB] = 1'b0;
        pulse(BPV);
        chk("irq1_out", 8'h08, irq1);
        rdc(5'h16, 8'h00);
        pulse(BPV);
        rdc(5'h17, 8'h02);
        rdc(5'h17, 8'h03);
        ev[BPV] = 1'b1;
        tick(253);
        ev[BPV] = 1'b0;
        rdc(5'h16, 8'h01);
        rdc(5'h17, 8'h00);
        rdc(5'h1C, 8'h08);
        ev[CRC] = 1'b1;
        tick(257);
        ev[CRC] = 1'b0;
        rdc(5'h18, 8'h01);
        rdc(5'h19, 8'h01);
        rdc(5'h1C, 8'h40);
        pulse(YEL);
        rdc(5'h1C, 8'h20);
        um1 = 8'hDF;
        pulse(YEL);
        um1 = 8'hFF;
        tick();
        rdc(5'h1C, 8'h00);
        pulse(PRB);
        rdc(5'h1C, 8'h04);
        pulse(DL);
        rdc(5'h1C, 8'h02);
        ev[B8] = 1'b1;
        pulse(DL);
        rdc(5'h1C, 8'h00);
        zrun(8);
        ev[B8] = 1'b0;
        zrun(16);
        results();
    end
endmodule // tpc_perf_irq_tb_top
